// ===== src/ebr_consts.svh
`ifndef EBR_CONSTS_SVH
`define EBR_CONSTS_SVH

// ==========================================================
// Memory map
`define EBR_RAM0_TOP 16'h00c0
`define EBR_RAM1_BASE 16'h0100
`define EBR_RAM1_TOP 16'h0200
`define EBR_ROM_BASE 16'h8000
`define EBR_RAM_WORDS 448
`define EBR_RAM1_OFS 9'h0c0

// ==========================================================
// Timing
`define EBR_CLK_NS 40
`define EBR_RST_MIN_NS 2000
`define EBR_RST_MIN_CYC ((`EBR_RST_MIN_NS + `EBR_CLK_NS - 1) / `EBR_CLK_NS)
`define EBR_STB_LAST 2'h3
`define EBR_ROM_LAST 2'h3
`define EBR_PHASE_LAST 2'h3

// ==========================================================
// Port indices and pin groups
`define EBR_P_ALO 0
`define EBR_P_AHI 1
`define EBR_P_DAT 2
`define EBR_P_MF 3
`define EBR_P_AN 4
`define EBR_P_SD 5
`define EBR_P_SC 6
`define EBR_SC_CTL_LSB 3

`endif

// ===== src/ebr_pkg.sv
package ebr_pkg;

	// ==========================================================
	// Processor modes and bus sequencer states
	typedef enum logic [1:0] {EBR_SINGLE, EBR_EXPAND, EBR_MICRO} ebr_mode_e;

	typedef enum logic [2:0] {
		EBR_IDLE, EBR_RAM_RD, EBR_ROM_WAIT, EBR_EXT_WAIT, EBR_EXT_ADDR, EBR_EXT_STB,
		EBR_EXT_END
	} ebr_state_e;

	typedef enum logic [1:0] {EBR_REG_RAM, EBR_REG_ROM, EBR_REG_EXT, EBR_REG_NONE} ebr_region_e;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic fetch;
	} ebr_req_s;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] out;
	} ebr_port_cfg_s;

	typedef logic [6:0][7:0] ebr_pins_t;

endpackage

// ===== src/ebr_clkdiv.sv
`include "ebr_consts.svh"

module ebr_clkdiv
	import ebr_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	output logic [1:0] phase_q,
	output logic phi_q
);

	logic [1:0] phase_d;

	// ==========================================================
	// Quarter-rate timing clock
	// Phi is high in phases 2 and 3, so it always equals phase bit 1
	assign phase_d = phase_q + 2'h1;

	always_ff @(posedge mclk) begin
		if (srst) begin
			phase_q <= 2'h0;
			phi_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			phi_q <= phase_d[1];
		end
	end

endmodule

// ===== src/ebr_bus.sv
// What this block does
// - Timing clock is oscillator divided by four
// - Fetch marker high only during opcode fetch
// - Direction level high on read, low write
// - Per-pin direction bit selects input or output
// - Low address byte on port outside single-chip
// - High address byte on port outside single-chip
// - Data port becomes bus outside single-chip mode
// - Slave mode turns slave port into data bus
// - Slave mode makes upper control pins inputs
// - Lower control pins usable as interrupt inputs
// - Multi-function pins selectable for peripheral use
// - Analog pins readable as digital inputs
// - Read strobe low while reading external data
// - Write strobe low while driving write data
// - Peripheral reset output high during reset
// - Dedicated socket address out, data in
// - Top half of space is socket memory
// - RAM at zero page low part, page one
// - Socket offset drops top address bit
`include "ebr_consts.svh"

module ebr_bus
	import ebr_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic processor_mode_pin,
	input wire ebr_mode_e mode_sel,
	input wire logic slave_mode,
	input wire logic [2:0] int_pin_en,
	input wire logic [7:0] mf_fn_sel,
	input wire logic [7:0] mf_fn_out,
	input wire logic [7:0] mf_fn_oe,
	input wire logic [7:0] slave_out,
	input wire logic slave_oe,
	input wire ebr_port_cfg_s [6:0] port_cfg,
	input wire logic req_valid,
	input wire ebr_req_s req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	input wire ebr_pins_t pin_i,
	output ebr_pins_t pin_o,
	output ebr_pins_t pin_oe,
	output ebr_pins_t pin_val,
	output logic [2:0] ext_irq,
	output logic [4:0] slave_ctl,
	output ebr_mode_e mode_q,
	output logic [14:0] rom_addr,
	input wire logic [7:0] rom_data,
	output logic rd_n,
	output logic wr_n,
	output logic rw,
	output logic sync,
	output logic phi,
	output logic rst_out
);

	ebr_state_e state_q;
	ebr_req_s cur_q;
	logic [1:0] cnt_q;
	logic [1:0] phase;
	logic [7:0] ram [0:`EBR_RAM_WORDS-1];
	ebr_pins_t pin_m_q;
	ebr_pins_t pin_s_q;
	logic [7:0] rom_m_q;
	logic [7:0] rom_s_q;
	logic mode_m_q;
	logic mode_s_q;
	logic ext_on;
	logic ext_rd;
	logic ext_wr;
	logic bus_busy;
	ebr_pins_t pin_o_d;
	ebr_pins_t pin_oe_d;

	// ==========================================================
	// Address decode
	function automatic ebr_region_e region(input logic [15:0] a, input ebr_mode_e m);
		if (a >= `EBR_ROM_BASE)
			return EBR_REG_ROM;
		else if (a < `EBR_RAM0_TOP)
			return EBR_REG_RAM;
		else if (a >= `EBR_RAM1_BASE && a < `EBR_RAM1_TOP)
			return EBR_REG_RAM;
		else if (m != EBR_SINGLE)
			return EBR_REG_EXT;
		else
			return EBR_REG_NONE;
	endfunction

	// Packs both RAM pages into one 448-word array
	function automatic logic [8:0] ram_index(input logic [15:0] a);
		if (a[8])
			return `EBR_RAM1_OFS + {1'b0, a[7:0]};
		else
			return {1'b0, a[7:0]};
	endfunction

	// ==========================================================
	// Quarter-rate clock
	ebr_clkdiv u_clkdiv (
		.mclk(mclk),
		.srst(srst),
		.phase_q(phase),
		.phi_q(phi)
	);

	// ==========================================================
	// Input synchronisers; every pin is asynchronous to mclk
	always_ff @(posedge mclk) begin
		pin_m_q <= pin_i;
		pin_s_q <= pin_m_q;
		rom_m_q <= rom_data;
		rom_s_q <= rom_m_q;
		mode_m_q <= processor_mode_pin;
		mode_s_q <= mode_m_q;
	end

	// ==========================================================
	// Processor mode
	// Mode pin is a static strap, so a synchronised level is enough
	always_ff @(posedge mclk) begin
		if (srst)
			mode_q <= EBR_SINGLE;
		else if (mode_s_q)
			mode_q <= EBR_MICRO;
		else
			mode_q <= mode_sel;
	end

	// ==========================================================
	// Peripheral reset output
	always_ff @(posedge mclk) begin
		rst_out <= srst;
	end

	// ==========================================================
	// Bus sequencer
	// External cycles start on phase 0 so strobes sit inside one phi period
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= EBR_IDLE;
			cur_q <= '0;
			cnt_q <= 2'h0;
		end else begin
			case (state_q)
				EBR_IDLE: begin
					cnt_q <= 2'h0;
					if (req_valid) begin
						cur_q <= req;
						case (region(req.addr, mode_q))
							EBR_REG_RAM: state_q <= EBR_RAM_RD;
							EBR_REG_ROM: state_q <= EBR_ROM_WAIT;
							EBR_REG_EXT: state_q <= EBR_EXT_WAIT;
							default: state_q <= EBR_RAM_RD;
						endcase
					end
				end
				EBR_RAM_RD: state_q <= EBR_IDLE;
				EBR_ROM_WAIT: begin
					// Covers address register plus two synchroniser stages
					cnt_q <= cnt_q + 2'h1;
					if (cnt_q == `EBR_ROM_LAST)
						state_q <= EBR_IDLE;
				end
				EBR_EXT_WAIT: begin
					if (phase == `EBR_PHASE_LAST)
						state_q <= EBR_EXT_ADDR;
				end
				EBR_EXT_ADDR: state_q <= EBR_EXT_STB;
				EBR_EXT_STB: begin
					cnt_q <= cnt_q + 2'h1;
					if (cnt_q == `EBR_STB_LAST)
						state_q <= EBR_EXT_END;
				end
				EBR_EXT_END: state_q <= EBR_IDLE;
				default: state_q <= EBR_IDLE;
			endcase
		end
	end

	assign bus_busy = (state_q != EBR_IDLE);
	assign ext_on = (state_q == EBR_EXT_ADDR) || (state_q == EBR_EXT_STB);
	assign ext_rd = (state_q == EBR_EXT_STB) && !cur_q.we;
	assign ext_wr = (state_q == EBR_EXT_STB) && cur_q.we;

	// ==========================================================
	// Internal RAM; writes complete in the accept cycle
	always_ff @(posedge mclk) begin
		if (!srst && !bus_busy && req_valid && req.we &&
				region(req.addr, mode_q) == EBR_REG_RAM)
			ram[ram_index(req.addr)] <= req.wdata;
	end

	// ==========================================================
	// Answer to the core
	always_ff @(posedge mclk) begin
		if (srst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			req_ready <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			req_ready <= !bus_busy && !req_valid;
			case (state_q)
				EBR_RAM_RD: begin
					rsp_valid <= 1'b1;
					if (region(cur_q.addr, mode_q) == EBR_REG_RAM)
						rsp_data <= ram[ram_index(cur_q.addr)];
					else
						rsp_data <= 8'h00;
				end
				EBR_ROM_WAIT: begin
					if (cnt_q == `EBR_ROM_LAST) begin
						rsp_valid <= 1'b1;
						rsp_data <= rom_s_q;
					end
				end
				EBR_EXT_STB: begin
					if (cnt_q == `EBR_STB_LAST && !cur_q.we)
						rsp_data <= pin_s_q[`EBR_P_DAT];
				end
				EBR_EXT_END: begin
					rsp_valid <= 1'b1;
					if (cur_q.we)
						rsp_data <= cur_q.wdata;
				end
				default: begin
					rsp_valid <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Socket memory port
	// Dropping bit 15 keeps processor and socket offsets aligned
	always_ff @(posedge mclk) begin
		if (srst)
			rom_addr <= 15'h0000;
		else if (!bus_busy && req_valid)
			rom_addr <= req.addr[14:0];
	end

	// ==========================================================
	// Bus control strobes, one cycle behind the sequencer state
	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			rw <= 1'b1;
			sync <= 1'b0;
		end else begin
			rd_n <= !ext_rd;
			wr_n <= !ext_wr;
			rw <= !(ext_on && cur_q.we);
			sync <= bus_busy && cur_q.fetch;
		end
	end

	// ==========================================================
	// Pin function multiplexing
	always_comb begin
		pin_o_d = '0;
		pin_oe_d = '0;
		// General I/O by default, one direction bit per pin
		for (int p = 0; p < 7; p++) begin
			pin_o_d[p] = port_cfg[p].out;
			pin_oe_d[p] = port_cfg[p].dir;
		end
		// Analog pins never drive; their value still reads back
		pin_oe_d[`EBR_P_AN] = 8'h00;
		if (mode_q != EBR_SINGLE) begin
			pin_o_d[`EBR_P_ALO] = cur_q.addr[7:0];
			pin_oe_d[`EBR_P_ALO] = 8'hff;
			pin_o_d[`EBR_P_AHI] = cur_q.addr[15:8];
			pin_oe_d[`EBR_P_AHI] = 8'hff;
			// Data lines float except while a write is on the bus
			pin_o_d[`EBR_P_DAT] = cur_q.wdata;
			pin_oe_d[`EBR_P_DAT] = (ext_on && cur_q.we) ? 8'hff : 8'h00;
		end
		for (int b = 0; b < 8; b++) begin
			if (mf_fn_sel[b]) begin
				pin_o_d[`EBR_P_MF][b] = mf_fn_out[b];
				pin_oe_d[`EBR_P_MF][b] = mf_fn_oe[b];
			end
		end
		if (slave_mode) begin
			// The master owns the direction through the slave-port logic
			pin_o_d[`EBR_P_SD] = slave_out;
			pin_oe_d[`EBR_P_SD] = slave_oe ? 8'hff : 8'h00;
			pin_oe_d[`EBR_P_SC][7:`EBR_SC_CTL_LSB] = 5'h00;
		end
		for (int i = 0; i < 3; i++) begin
			if (int_pin_en[i])
				pin_oe_d[`EBR_P_SC][i] = 1'b0;
		end
	end

	// ==========================================================
	// Registered pin drivers and readback
	// Reset releases every pin so nothing fights a board strap
	always_ff @(posedge mclk) begin
		if (srst) begin
			pin_o <= '0;
			pin_oe <= '0;
			pin_val <= '0;
			ext_irq <= 3'h0;
			slave_ctl <= 5'h00;
		end else begin
			pin_o <= pin_o_d;
			pin_oe <= pin_oe_d;
			pin_val <= pin_s_q;
			ext_irq <= pin_s_q[`EBR_P_SC][2:0] & int_pin_en;
			slave_ctl <= slave_mode ? pin_s_q[`EBR_P_SC][7:`EBR_SC_CTL_LSB] : 5'h00;
		end
	end

endmodule

// ===== verification/ebr_bus_checker.sv
module ebr_bus_checker
	import ebr_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic req_valid,
	input wire ebr_req_s req,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire ebr_pins_t pin_o,
	input wire ebr_pins_t pin_oe,
	input wire ebr_mode_e mode_q,
	input wire logic [14:0] rom_addr,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic rw,
	input wire logic sync,
	input wire logic phi,
	input wire logic rst_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// ========
	// Reset, clock output and strobes
	a_rst_out_high: assert property (disable iff (1'b0) srst |=> rst_out)
		else $error("rst_out low in reset");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> pin_oe == '0 && rd_n && wr_n
		&& mode_q == EBR_SINGLE) else $error("pins not quiet in reset");
	a_phi_quarter: assert property ($rose(phi) |=> phi ##1 !phi ##1 !phi ##1 phi)
		else $error("phi not quarter rate");
	a_read_dir: assert property (!rd_n |-> rw && wr_n && pin_oe[2] == 8'h00)
		else $error("read strobe with wrong direction");
	a_write_dir: assert property (!wr_n |-> !rw && pin_oe[2] == 8'hff)
		else $error("write strobe without data drive");
	a_read_len: assert property ($fell(rd_n) |=> !rd_n [*3] ##1 rd_n)
		else $error("read strobe length wrong");
	a_addr_out: assert property ((!rd_n || !wr_n) |-> pin_o[0] == req.addr[7:0]
		&& pin_o[1] == req.addr[15:8] && pin_oe[1] == 8'hff) else $error("bus address wrong");
	a_sync_fetch: assert property (sync |-> req.fetch)
		else $error("sync outside fetch");
	// Answer latency ties region decode to the request
	a_rom_lat: assert property ($rose(req_valid) && req.addr[15] |-> ##5 rsp_valid)
		else $error("socket answer late");
	a_ram_lat: assert property ($rose(req_valid) && req.addr < 16'h0200 |->
		##2 rsp_valid ##1 !rsp_valid) else $error("ram answer wrong");
	a_rom_map: assert property ($rose(req_valid) && req.addr[15] |->
		##[1:5] rom_addr == req.addr[14:0]) else $error("socket offset wrong");
	// A taken request must drop the idle hint
	a_ready_busy: assert property ($rose(req_valid) |=> !req_ready)
		else $error("ready high while busy");
	c_rom: cover property ($rose(req_valid) && req.addr[15]);
	c_ext_rd: cover property ($fell(rd_n));
	c_ext_wr: cover property ($fell(wr_n));
endmodule

bind ebr_bus ebr_bus_checker chk_i (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req(req),
	.req_ready(req_ready),
	.rsp_valid(rsp_valid), .pin_o(pin_o), .pin_oe(pin_oe), .mode_q(mode_q), .rom_addr(rom_addr),
	.rd_n(rd_n), .wr_n(wr_n), .rw(rw), .sync(sync), .phi(phi), .rst_out(rst_out));

// ===== verification/ebr_ext_mem.sv
module ebr_ext_mem
	import ebr_pkg::*;
(
	input wire logic mclk,
	input wire logic [14:0] rom_addr,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] addr_lo,
	input wire logic [7:0] dat_o,
	input wire logic [7:0] dat_oe,
	output logic [7:0] rom_data,
	output logic [7:0] bus
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	logic [7:0] last_q;
	logic [7:0] far;
	// ========
	// Socket memory: pattern of upper offset bits, so a wrong offset shows
	assign rom_data = rom_addr[14:7];
	// Memory drives only while strobed; a released bus toggles, no stale value
	assign far = !rd_n ? mem[addr_lo] : ~last_q;
	assign bus = (dat_o & dat_oe) | (far & ~dat_oe);
	// Write captured while the strobe is low
	always_ff @(posedge mclk) begin
		last_q <= bus;
		if (!wr_n) begin
			mem[addr_lo] <= dat_o;
		end
	end
endmodule

// ===== verification/mcu_external_bus_and_rom_socket_bench.sv
module mcu_external_bus_and_rom_socket_bench;
	import ebr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, srst, slave_mode, slave_oe, req_valid, req_ready, rsp_valid, strap;
	logic rd_n, wr_n, rw, sync, phi, rst_out;
	ebr_mode_e mode_sel, mode_q;
	logic [2:0] int_pin_en, ext_irq;
	logic [4:0] slave_ctl;
	logic [7:0] mf_fn_sel, mf_fn_out, mf_fn_oe, slave_out, rsp_data, rom_data, ext_bus, q;
	logic [14:0] rom_addr;
	ebr_port_cfg_s [6:0] port_cfg;
	ebr_req_s req;
	ebr_pins_t pin_i, pin_o, pin_oe, pin_val, tb_pin;
	int num_errors = 0;
	int tests_run = 0;
	// ========
	// Design, far-side memories and pin resolution
	ebr_bus uut (.mclk(mclk), .srst(srst), .processor_mode_pin(strap),
		.mode_sel(mode_sel), .slave_mode(slave_mode), .int_pin_en(int_pin_en),
		.mf_fn_sel(mf_fn_sel), .mf_fn_out(mf_fn_out), .mf_fn_oe(mf_fn_oe),
		.slave_out(slave_out), .slave_oe(slave_oe), .port_cfg(port_cfg), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_val(pin_val), .ext_irq(ext_irq),
		.slave_ctl(slave_ctl), .mode_q(mode_q), .rom_addr(rom_addr), .rom_data(rom_data),
		.rd_n(rd_n), .wr_n(wr_n), .rw(rw), .sync(sync), .phi(phi), .rst_out(rst_out));
	ebr_ext_mem mem_i (.mclk(mclk), .rom_addr(rom_addr), .rd_n(rd_n), .wr_n(wr_n),
		.addr_lo(pin_o[0]), .dat_o(pin_o[2]), .dat_oe(pin_oe[2]), .rom_data(rom_data), .bus(ext_bus));
	// Wire level: design drive wins bit by bit, else the bench value (the far-side memory on port 2)
	always_comb begin
		for (int p = 0; p < 7; p++) begin
			pin_i[p] = (pin_o[p] & pin_oe[p]) | (tb_pin[p] & ~pin_oe[p]);
		end
		pin_i[2] = ext_bus;
	end
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// ========
	// Tasks
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Request dropped after the take edge so it is never taken twice
	task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w, input logic f,
		output logic [7:0] rd);
		int n;
		n = 0;
		req <= '{addr: a, wdata: d, we: w, fetch: f};
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (rsp_valid !== 1'b1 && n < 20);
		chk("rsp_valid", 1'b1, rsp_valid);
		rd = rsp_data;
		@(posedge mclk);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, far above the roughly 90 cycles of the tests
	initial begin
		#100us;
		num_errors++;
		report_and_stop();
	end
	// ========
	// Tests
	initial begin
		srst = 1'b1;
		strap = 1'b0;
		mode_sel = EBR_SINGLE;
		{slave_mode, slave_oe, req_valid, int_pin_en} = '0;
		{mf_fn_sel, mf_fn_out, mf_fn_oe, slave_out} = '0;
		port_cfg = '0;
		req = '0;
		tb_pin = '0;
		repeat (20) @(posedge mclk);
		#1;
		chk("rst_out", 1'b1, rst_out);
		chk("pin_oe", 1'b0, |pin_oe);
		chk("mode_q", EBR_SINGLE, mode_q);
		@(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		#1;
		chk("req_ready", 1'b1, req_ready);
		@(posedge mclk);
		$display("test reset done");
		access(16'h0005, 8'ha5, 1'b1, 1'b0, q);
		access(16'h01ff, 8'h3c, 1'b1, 1'b0, q);
		access(16'h0005, 8'h00, 1'b0, 1'b0, q);
		chk("ram low", 8'ha5, q);
		access(16'h01ff, 8'h00, 1'b0, 1'b0, q);
		chk("ram page one", 8'h3c, q);
		$display("test ram done");
		access(16'hf000, 8'h00, 1'b0, 1'b1, q);
		chk("socket f000", 8'he0, q);
		access(16'h8100, 8'h00, 1'b0, 1'b0, q);
		chk("socket 8100", 8'h02, q);
		$display("test socket done");
		mode_sel <= EBR_EXPAND;
		repeat (4) @(posedge mclk);
		access(16'h0342, 8'h96, 1'b1, 1'b0, q);
		access(16'h0342, 8'h00, 1'b0, 1'b0, q);
		#1;
		chk("ext data", 8'h96, q);
		chk("addr low", 8'h42, pin_o[0]);
		chk("addr high", 8'h03, pin_o[1]);
		@(posedge mclk);
		$display("test external done");
		mode_sel <= EBR_SINGLE;
		port_cfg[0] <= '{dir: 8'hff, out: 8'h81};
		port_cfg[3] <= '{dir: 8'hf0, out: 8'ha5};
		tb_pin[4] <= 8'h3c;
		repeat (5) @(posedge mclk);
		#1;
		chk("gpio port0", 8'h81, pin_o[0]);
		chk("gpio dir", 8'hf0, pin_oe[3]);
		chk("gpio out", 8'ha0, pin_o[3] & 8'hf0);
		chk("analog val", 8'h3c, pin_val[4]);
		chk("analog oe", 8'h00, pin_oe[4]);
		$display("test gpio done");
		@(posedge mclk);
		port_cfg[6] <= '{dir: 8'hff, out: 8'h00};
		{slave_mode, slave_oe, slave_out, tb_pin[6], int_pin_en} <= {2'b11, 8'hc3, 8'hab, 3'b101};
		{mf_fn_sel, mf_fn_out, mf_fn_oe} <= {8'h0f, 8'h05, 8'h0f};
		repeat (5) @(posedge mclk);
		#1;
		chk("slave data", 8'hc3, pin_o[5]);
		chk("slave oe", 8'hff, pin_oe[5]);
		chk("slave ctl", 5'h15, slave_ctl);
		chk("ctl oe", 5'h00, pin_oe[6][7:3]);
		chk("ext irq", 3'h1, ext_irq);
		chk("mf out", 4'h5, pin_o[3][3:0]);
		$display("test pin functions done");
		// Strap high forces the microprocessor mode after its synchroniser
		@(posedge mclk);
		strap <= 1'b1;
		repeat (5) @(posedge mclk);
		#1;
		chk("mode strap", EBR_MICRO, mode_q);
		$display("test strap done");
		report_and_stop();
	end
endmodule
